//--- bss_pkg.sv
package bss_pkg;
  // ----------------------------------------------------------------
  // configuration defaults
  // ----------------------------------------------------------------
  localparam int          BSS_REGION_BYTES_DEF = 1024;
  localparam int          BSS_DATA_W_DEF       = 32;
  localparam logic [31:0] BSS_BASE_DEF         = 32'h0000_0000;
  localparam logic [31:0] BSS_INIT_DEF         = 32'h0000_0000;
  localparam int          BSS_INIT_W_DEF       = 32;
  localparam int          BSS_NUM_SIG_IN       = 4;
  localparam int          BSS_NUM_SIG_OUT      = 4;

  // ----------------------------------------------------------------
  // master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSS_M_IDLE = 2'b00,
    BSS_M_REQ  = 2'b01,
    BSS_M_WAIT = 2'b11
  } bss_mst_t;
endpackage

//--- bss_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module bss_slave_model (
  input  wire logic        clock_i,   // clock
  input  wire logic        nrst_i,    // reset
  input  wire logic        m_req_i,   // request
  input  wire logic        m_we_i,    // write
  input  wire logic [31:0] m_addr_i,  // address
  input  wire logic [31:0] m_wdata_i, // write data
  input  wire logic [3:0]  lat_i,     // wait cycles
  output logic             m_ack_o,   // ack pulse
  output logic [31:0]      m_rdata_o, // read data
  output logic [31:0]      wr_o       // last write
);
  typedef struct packed {logic ack; logic [3:0] cnt; logic [31:0] rdata; logic [31:0] wr;} bss_pm_t;
  bss_pm_t state_reg;
  bss_pm_t state_next;

  // answer after lat_i waits; data toggles when not valid
  always_comb
  begin
    state_next       = state_reg;
    state_next.ack   = 1'b0;
    state_next.rdata = ~state_reg.rdata;
    if (m_req_i && !state_reg.ack)
    begin
      state_next.cnt = state_reg.cnt + 4'h1;
      if (state_reg.cnt == lat_i)
      begin
        state_next     = '{1'b1, 4'h0, ~m_addr_i, m_we_i ? m_wdata_i : state_reg.wr};
      end
    end
  end

  // state register
  always_ff @(posedge clock_i)
    if (!nrst_i) state_reg <= '0;
    else state_reg <= state_next;

  assign m_ack_o   = state_reg.ack;
  assign m_rdata_o = state_reg.rdata;
  assign wr_o      = state_reg.wr;
endmodule

`default_nettype wire

//--- bss_stub.sv
`timescale 1ns/1ps
`default_nettype none

module bss_stub
  import bss_pkg::*;
#(
  parameter int          DATA_W       = BSS_DATA_W_DEF,       // 32 or 64
  parameter int          REGION_BYTES = BSS_REGION_BYTES_DEF,
  parameter logic [31:0] BASE_ADDR    = BSS_BASE_DEF,
  parameter int          INIT_W       = BSS_INIT_W_DEF,        // 8 or 16 repeat; anything wider fills from the low 32 bits
  parameter logic [63:0] INIT_VALUE   = {32'h0000_0000, BSS_INIT_DEF},
  parameter int          SIG_OUT_W    = BSS_NUM_SIG_OUT
)(
  input  wire logic                  clock_i,        // system clock
  input  wire logic                  nrst_i,         // sync reset, low
  input  wire logic                  clk_en_i,       // freezes state when low
  input  wire logic                  big_endian_i,   // slave byte order
  input  wire logic                  trace_en_i,     // slave cycle trace
  // slave port
  input  wire logic                  s_req_i,        // access request
  input  wire logic                  s_we_i,         // write when high
  input  wire logic [31:0]           s_addr_i,       // byte address
  input  wire logic [DATA_W-1:0]     s_wdata_i,      // write data
  input  wire logic [DATA_W/8-1:0]   s_be_i,         // byte enables
  output logic                       s_ack_o,        // claimed, one cycle
  output logic [DATA_W-1:0]          s_rdata_o,      // read data
  // sequence command port
  input  wire logic                  cmd_valid_i,    // start master access
  input  wire logic                  cmd_we_i,       // write when high
  input  wire logic [31:0]           cmd_addr_i,     // target address
  input  wire logic [DATA_W-1:0]     cmd_wdata_i,    // write data
  input  wire logic [DATA_W/8-1:0]   cmd_be_i,       // byte enables
  output logic                       cmd_ready_o,    // idle, may accept
  output logic                       cmd_done_o,     // access done pulse
  output logic [DATA_W-1:0]          cmd_rdata_o,    // read result
  // master port
  output logic                       m_req_o,        // request level
  output logic                       m_we_o,         // write when high
  output logic [31:0]                m_addr_o,       // byte address
  output logic [DATA_W-1:0]          m_wdata_o,      // write data
  output logic [DATA_W/8-1:0]        m_be_o,         // byte enables
  input  wire logic                  m_ack_i,        // slave acknowledge
  input  wire logic [DATA_W-1:0]     m_rdata_i,      // read data
  // signal ports
  input  wire logic [BSS_NUM_SIG_IN-1:0] sig_in_i,   // async signal inputs
  output logic [BSS_NUM_SIG_IN-1:0]  sig_event_o,    // change pulse per input
  input  wire logic                  sig_out_we_i,   // load signal outputs
  input  wire logic [SIG_OUT_W-1:0]  sig_out_val_i,  // new output value
  output logic [SIG_OUT_W-1:0]       sig_out_o,      // driven signal outputs
  // trace
  output logic                       trc_valid_o,    // trace record pulse
  output logic                       trc_we_o,       // traced direction
  output logic [31:0]                trc_addr_o,     // traced address
  output logic [DATA_W-1:0]          trc_data_o      // traced data
);
  // ----------------------------------------------------------------
  // geometry and fill word
  // ----------------------------------------------------------------
  localparam int NB    = DATA_W / 8;
  localparam int WORDS = REGION_BYTES / NB;
  localparam int AW    = $clog2(WORDS);
  localparam int OW    = $clog2(NB);

  // fill word built from the pattern width
  localparam logic [31:0] FILL32 =
    (INIT_W <= 8)  ? {4{INIT_VALUE[7:0]}} :
    (INIT_W <= 16) ? {2{INIT_VALUE[15:0]}} :
    INIT_VALUE[31:0];
  localparam logic [DATA_W-1:0] FILL = {(DATA_W/32){FILL32}};

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    init_busy;
    logic [AW-1:0]           init_ptr;
    logic                    s_ack;
    logic [DATA_W-1:0]       s_rdata;
    bss_mst_t                mst;
    logic                    rdy;
    logic                    m_we;
    logic [31:0]             m_addr;
    logic [DATA_W-1:0]       m_wdata;
    logic [NB-1:0]           m_be;
    logic                    done;
    logic [DATA_W-1:0]       rdata;
    logic [BSS_NUM_SIG_IN-1:0] s1, s2, s3;
    logic [BSS_NUM_SIG_IN-1:0] stable;
    logic [BSS_NUM_SIG_IN-1:0] evt;
    logic [SIG_OUT_W-1:0]    sig_out;
    logic                    trc_v;
    logic                    trc_we;
    logic [31:0]             trc_addr;
    logic [DATA_W-1:0]       trc_data;
  } bss_state_t;

  bss_state_t st_reg, st_next;
  logic [DATA_W-1:0] mem [WORDS];

  // ----------------------------------------------------------------
  // slave decode helpers
  // ----------------------------------------------------------------
  logic [31:0]       s_off;
  logic              s_hit;
  logic [AW-1:0]     s_idx;
  logic [DATA_W-1:0] s_wd_sw;
  logic [NB-1:0]     s_be_sw;
  logic [DATA_W-1:0] rd_word;

  // lane swap for big endian byte order
  function automatic logic [DATA_W-1:0] swap_b(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < NB; i++)
      r[8*i +: 8] = d[8*(NB-1-i) +: 8];
    return r;
  endfunction

  function automatic logic [NB-1:0] swap_e(input logic [NB-1:0] e);
    logic [NB-1:0] r;
    r = '0;
    for (int i = 0; i < NB; i++)
      r[i] = e[NB-1-i];
    return r;
  endfunction

  // window check and index
  assign s_off   = s_addr_i - BASE_ADDR;
  assign s_hit   = s_req_i && (s_addr_i >= BASE_ADDR)
                   && (s_off < 32'(REGION_BYTES));
  assign s_idx   = s_off[AW+OW-1:OW];
  assign s_wd_sw = big_endian_i ? swap_b(s_wdata_i) : s_wdata_i;
  assign s_be_sw = big_endian_i ? swap_e(s_be_i) : s_be_i;
  assign rd_word = mem[s_idx];

  // ----------------------------------------------------------------
  // memory array: fill at init, then slave writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (clk_en_i)
    begin
      if (st_reg.init_busy)
        mem[st_reg.init_ptr] <= FILL;
      else if (s_hit && s_we_i)
      begin
        for (int i = 0; i < NB; i++)
          if (s_be_sw[i])
            mem[s_idx][8*i +: 8] <= s_wd_sw[8*i +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next       = st_reg;
    st_next.s_ack = 1'b0;
    st_next.done  = 1'b0;
    st_next.trc_v = 1'b0;
    // fill walk; slave held off until done
    if (st_reg.init_busy)
    begin
      st_next.init_ptr = st_reg.init_ptr + 1'b1;
      if (st_reg.init_ptr == AW'(WORDS - 1))
        st_next.init_busy = 1'b0;
    end
    else if (s_hit)
    begin
      st_next.s_ack   = 1'b1;
      st_next.s_rdata = big_endian_i ? swap_b(rd_word) : rd_word;
      if (trace_en_i)
      begin
        st_next.trc_v    = 1'b1;
        st_next.trc_we   = s_we_i;
        st_next.trc_addr = s_addr_i;
        st_next.trc_data = s_we_i ? s_wdata_i : st_next.s_rdata;
      end
    end
    // master sequencer
    case (st_reg.mst)
      BSS_M_IDLE:
        if (cmd_valid_i)
        begin
          st_next.mst     = BSS_M_REQ;
          st_next.m_we    = cmd_we_i;
          st_next.m_addr  = cmd_addr_i;
          st_next.m_wdata = cmd_wdata_i;
          st_next.m_be    = cmd_be_i;
        end
      BSS_M_REQ,
      BSS_M_WAIT:
        if (m_ack_i)
        begin
          st_next.mst   = BSS_M_IDLE;
          st_next.done  = 1'b1;
          if (!st_reg.m_we)
            st_next.rdata = m_rdata_i;
        end
        else
          st_next.mst = BSS_M_WAIT;
      default:
        st_next.mst = BSS_M_IDLE;
    endcase
    // registered ready so the output comes from a flop
    st_next.rdy = (st_next.mst == BSS_M_IDLE);
    // input sync and change detect on agreement of stages two and three
    st_next.s1  = sig_in_i;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.evt = '0;
    for (int i = 0; i < BSS_NUM_SIG_IN; i++)
      if (st_reg.s2[i] == st_reg.s3[i] && st_reg.s3[i] != st_reg.stable[i])
      begin
        st_next.stable[i] = st_reg.s3[i];
        st_next.evt[i]    = 1'b1;
      end
    // signal outputs
    if (sig_out_we_i)
      st_next.sig_out = sig_out_val_i;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      st_reg           <= '0;
      st_reg.init_busy <= 1'b1;
      st_reg.mst       <= BSS_M_IDLE;
      st_reg.rdy       <= 1'b1;
    end
    else if (clk_en_i)
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_ack_o     = st_reg.s_ack;
  assign s_rdata_o   = st_reg.s_rdata;
  assign cmd_ready_o = st_reg.rdy;
  assign cmd_done_o  = st_reg.done;
  assign cmd_rdata_o = st_reg.rdata;
  assign m_req_o     = st_reg.mst[0];  // low bit set in both busy states
  assign m_we_o      = st_reg.m_we;
  assign m_addr_o    = st_reg.m_addr;
  assign m_wdata_o   = st_reg.m_wdata;
  assign m_be_o      = st_reg.m_be;
  assign sig_event_o = st_reg.evt;
  assign sig_out_o   = st_reg.sig_out;
  assign trc_valid_o = st_reg.trc_v;
  assign trc_we_o    = st_reg.trc_we;
  assign trc_addr_o  = st_reg.trc_addr;
  assign trc_data_o  = st_reg.trc_data;
endmodule

`default_nettype wire

//--- bss_stub_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end

module bss_stub_bench;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam int          RB   = 64;
  logic clock_i = 0, nrst_i = 0, clk_en_i = 1, big_endian_i = 0, trace_en_i = 1;
  logic s_req_i = 0, s_we_i = 0, cmd_valid_i = 0, cmd_we_i = 0, sig_out_we_i = 0;
  logic [31:0] s_addr_i = '0, s_wdata_i = '0, cmd_addr_i = '0, cmd_wdata_i = '0;
  logic [3:0] s_be_i = 4'hF, cmd_be_i = 4'hF, sig_in_i = '0, sig_out_val_i = '0, lat = '0;
  logic s_ack_o, cmd_ready_o, cmd_done_o, m_req_o, m_we_o, m_ack_i, trc_valid_o, trc_we_o;
  logic [31:0] s_rdata_o, cmd_rdata_o, m_addr_o, m_wdata_o, m_rdata_i, trc_addr_o, trc_data_o;
  logic [3:0] m_be_o, sig_event_o, sig_out_o;
  logic [31:0] wr_seen, rd;
  logic ok;
  int mismatches = 0, checked = 0;

  always #2.5 clock_i = ~clock_i;

  bss_stub #(.REGION_BYTES(RB), .BASE_ADDR(BASE), .INIT_W(8), .INIT_VALUE(64'h0000_0000_0000_005A))
  i_bss_stub (.clock_i, .nrst_i, .clk_en_i, .big_endian_i, .trace_en_i, .s_req_i, .s_we_i,
    .s_addr_i, .s_wdata_i, .s_be_i, .s_ack_o, .s_rdata_o, .cmd_valid_i, .cmd_we_i, .cmd_addr_i,
    .cmd_wdata_i, .cmd_be_i, .cmd_ready_o, .cmd_done_o, .cmd_rdata_o, .m_req_o, .m_we_o,
    .m_addr_o, .m_wdata_o, .m_be_o, .m_ack_i, .m_rdata_i, .sig_in_i, .sig_event_o,
    .sig_out_we_i, .sig_out_val_i, .sig_out_o, .trc_valid_o, .trc_we_o, .trc_addr_o, .trc_data_o);

  bss_slave_model i_bss_slave_model (.clock_i, .nrst_i, .m_req_i(m_req_o), .m_we_i(m_we_o),
    .m_addr_i(m_addr_o), .m_wdata_i(m_wdata_o), .lat_i(lat), .m_ack_o(m_ack_i),
    .m_rdata_o(m_rdata_i), .wr_o(wr_seen));

  // wait n edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // one slave access: request one cycle, look at ack the next
  task automatic s_acc(input logic we, input logic [31:0] a, d, input logic [3:0] be);
    {s_req_i, s_we_i, s_addr_i, s_wdata_i, s_be_i} = {1'b1, we, a, d, be};
    tick(1);
    ok = s_ack_o;
    rd = s_rdata_o;
    if (ok === 1'b1) `CHK(trc_addr_o, a)
    s_req_i = 1'b0;
    tick(1);
  endtask

  // read and compare ack and data
  task automatic rd_chk(input logic [31:0] a, e, input logic hit);
    s_acc(1'b0, a, '0, 4'hF);
    `CHK(ok, hit)
    if (hit) `CHK(rd, e)
  endtask

  // one master command, bounded wait for done
  task automatic m_cmd(input logic we, input logic [31:0] a, d);
    int n;
    {cmd_valid_i, cmd_we_i, cmd_addr_i, cmd_wdata_i} = {1'b1, we, a, d};
    tick(1);
    cmd_valid_i = 1'b0;
    for (n = 0; n < 40 && cmd_done_o !== 1'b1; n++) tick(1);
    `CHK(cmd_done_o, 1'b1)
    rd = cmd_rdata_o;
  endtask

  // closing verdict
  task automatic end_of_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #20000;
    mismatches++;
    end_of_test();
  end

  // test sequence
  initial
  begin
    tick(6);
    nrst_i = 1'b1;
    rd_chk(BASE, '0, 1'b0);
    tick(RB / 4);
    rd_chk(BASE, 32'h5A5A_5A5A, 1'b1);
    rd_chk(BASE + RB - 4, 32'h5A5A_5A5A, 1'b1);
    rd_chk(BASE + RB, '0, 1'b0);
    rd_chk(BASE - 4, '0, 1'b0);
    s_acc(1'b1, BASE + 4, 32'h0000_00EE, 4'h1);
    rd_chk(BASE + 4, 32'h5A5A_5AEE, 1'b1);
    big_endian_i = 1'b1;
    s_acc(1'b1, BASE + 8, 32'h0000_00EE, 4'h1);
    rd_chk(BASE + 8, 32'h5A5A_5AEE, 1'b1);
    big_endian_i = 1'b0;
    rd_chk(BASE + 8, 32'hEE5A_5A5A, 1'b1);
    m_cmd(1'b1, 32'h0000_2000, 32'hCAFE_0001);
    `CHK(wr_seen, 32'hCAFE_0001)
    lat = 4'h5;
    m_cmd(1'b0, 32'h0000_2004, '0);
    `CHK(rd, ~32'h0000_2004)
    for (int i = 0; i < 4; i++)
    begin
      sig_in_i[i] = 1'b1;
      for (int n = 0; n < 12 && sig_event_o[i] !== 1'b1; n++) tick(1);
      `CHK(sig_event_o[i], 1'b1)
    end
    {sig_out_we_i, sig_out_val_i} = {1'b1, 4'hA};
    tick(1);
    sig_out_we_i = 1'b0;
    `CHK(sig_out_o, 4'hA)
    {clk_en_i, sig_out_we_i, sig_out_val_i} = {1'b0, 1'b1, 4'h5};
    tick(1);
    `CHK(sig_out_o, 4'hA)
    {clk_en_i, sig_out_we_i} = 2'b10;
    tick(2);
    end_of_test();
  end
endmodule

`default_nettype wire

//--- bss_stub_properties.sv
`timescale 1ns/1ps
`default_nettype none

module bss_stub_properties
  import bss_pkg::*;
#(
  parameter int          DATA_W       = BSS_DATA_W_DEF,
  parameter int          REGION_BYTES = BSS_REGION_BYTES_DEF,
  parameter logic [31:0] BASE_ADDR    = BSS_BASE_DEF,
  parameter int          SIG_OUT_W    = BSS_NUM_SIG_OUT
)(
  input wire logic                 clock_i,       // clock
  input wire logic                 nrst_i,        // reset
  input wire logic                 clk_en_i,      // enable
  input wire logic                 s_req_i,       // slave req
  input wire logic [31:0]          s_addr_i,      // slave addr
  input wire logic                 s_ack_o,       // slave ack
  input wire logic                 trc_valid_o,   // trace pulse
  input wire logic [31:0]          trc_addr_o,    // trace addr
  input wire logic                 cmd_valid_i,   // command
  input wire logic [31:0]          cmd_addr_i,    // command addr
  input wire logic                 cmd_ready_o,   // idle
  input wire logic                 cmd_done_o,    // done
  input wire logic                 m_req_o,       // master req
  input wire logic [31:0]          m_addr_o,      // master addr
  input wire logic                 m_ack_i,       // master ack
  input wire logic                 sig_out_we_i,  // output load
  input wire logic [SIG_OUT_W-1:0] sig_out_val_i, // output value
  input wire logic [SIG_OUT_W-1:0] sig_out_o      // outputs
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // slave port, trace, master handshake, signal outputs
  a_ack_has_req: assert property (s_ack_o |-> $past(s_req_i) && $past(clk_en_i))
    else $error("ack without request");
  a_ack_in_window: assert property (s_ack_o |-> ($past(s_addr_i) - BASE_ADDR) < REGION_BYTES)
    else $error("ack outside window");
  a_trace_match: assert property (trc_valid_o |-> s_ack_o && trc_addr_o == $past(s_addr_i))
    else $error("trace mismatch");
  a_cmd_launch: assert property (cmd_valid_i && cmd_ready_o && clk_en_i |=>
    m_req_o && m_addr_o == $past(cmd_addr_i))
    else $error("command not launched");
  a_req_holds: assert property (m_req_o && !m_ack_i |=> m_req_o && $stable(m_addr_o))
    else $error("request dropped");
  a_done_on_ack: assert property (m_req_o && m_ack_i && clk_en_i |=>
    cmd_done_o && !m_req_o && cmd_ready_o)
    else $error("no done after ack");
  a_ready_idle: assert property (cmd_ready_o |-> !m_req_o)
    else $error("ready while busy");
  a_sig_out_load: assert property (sig_out_we_i && clk_en_i |=> sig_out_o == $past(sig_out_val_i))
    else $error("outputs not loaded");
endmodule

bind bss_stub bss_stub_properties #(.DATA_W(DATA_W), .REGION_BYTES(REGION_BYTES),
  .BASE_ADDR(BASE_ADDR), .SIG_OUT_W(SIG_OUT_W)) i_bss_stub_properties (.clock_i, .nrst_i,
  .clk_en_i, .s_req_i, .s_addr_i, .s_ack_o, .trc_valid_o, .trc_addr_o, .cmd_valid_i,
  .cmd_addr_i, .cmd_ready_o, .cmd_done_o, .m_req_o, .m_addr_o, .m_ack_i, .sig_out_we_i,
  .sig_out_val_i, .sig_out_o);

`default_nettype wire
